/* File: verilog/satx_top.sv */
// serial audio port transmit section: three data outputs, clock, word select
// Contract
// - a data line is high while its transmitter is off, in reset or stop.
// - three independent transmitters 0 to 2 each drive their own data line.
// - the bit clock pin is an output as master and an input as slave.
// - as master the bit clock is generated inside and shown on the pin.
// - the bit clock pin floats when all are off, in reset, or in stop.
// - the word select pin is an output as master and an input as slave.
// - word select frames each word and marks the left or right channel.
// - the word select pin floats when all are off, in reset, or in stop.
// - a floating pin has its input buffer cut off from the logic.
// - the transmit section has its own clock and word select lines.
module satx_top #(
  parameter int WORD_BITS = satx_pkg::WORD_BITS,
  parameter int HALF = satx_pkg::BCLK_HALF
) (
  // system clock, reset, enable
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic CE,
  // control levels
  input wire logic MASTER,
  input wire logic [2:0] TX_ENABLE,
  input wire logic SW_RESET,
  input wire logic STOP,
  // sample words in (left then right per transmitter)
  input wire logic WORD_VALID,
  output logic WORD_READY,
  input wire logic [3*WORD_BITS-1:0] WORD_DATA,
  input wire logic WORD_RIGHT,
  // link clock in slave mode
  input wire logic TX_BIT_CLOCK_IN,
  // pins
  output logic TX_BIT_CLOCK_OUT,
  output logic TX_BIT_CLOCK_OE,
  input wire logic TX_WORD_SELECT_IN,
  output logic TX_WORD_SELECT_OUT,
  output logic TX_WORD_SELECT_OE,
  output logic SER_OUT_A,
  output logic SER_OUT_B,
  output logic SER_OUT_C
);
  localparam int CW = $clog2(WORD_BITS + 1);
  localparam int DW = 3 * WORD_BITS;

  // reset release
  logic rst_s1, rst;
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1 <= 1'b0;
      rst <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst <= rst_s1;
    end
  end

  wire any_en = |TX_ENABLE;
  // section inactive: all off, software reset or stop
  wire quiet = !any_en || SW_RESET || STOP;
  wire run = !quiet;
  wire master_run = run && MASTER;
  wire slave_run = run && !MASTER;

  // master clock generation on MCLK; the divider restarts at every start,
  // so the first half period on the pin is always full length
  logic [$clog2(HALF+1)-1:0] div;
  logic [$clog2(HALF+1)-1:0] next_div;
  logic gen_clk, gen_fall;
  wire div_end = (div == ($clog2(HALF+1))'(HALF - 1));
  wire gen_flip = master_run && div_end;
  assign next_div = (!master_run || div_end) ? '0 : div + 1'h1;
  wire next_gen_clk = master_run && (gen_clk ^ div_end);
  // one-tick pulse on the same edge that the generated clock falls, a tick before the pin falls
  wire next_gen_fall = gen_flip && gen_clk;
  always_ff @(posedge MCLK or negedge rst) begin
    if (!rst) begin
      div <= '0;
    end else if (CE) begin
      div <= next_div;
    end
  end

  always_ff @(posedge MCLK or negedge rst) begin
    if (!rst) begin
      gen_clk <= 1'h0;
    end else if (CE) begin
      gen_clk <= next_gen_clk;
    end
  end

  always_ff @(posedge MCLK or negedge rst) begin
    if (!rst) begin
      gen_fall <= 1'h0;
    end else if (CE) begin
      gen_fall <= next_gen_fall;
    end
  end

  // slave pins: gated when floating so no pull-up is needed
  wire sck_gated = TX_BIT_CLOCK_IN & slave_run;
  wire ws_gated = TX_WORD_SELECT_IN & slave_run;
  // two flops per pin against metastability; a third only finds the edge
  logic sck_s1, sck_s2, sck_s3, ws_s1, ws_s2;
  always_ff @(posedge MCLK or negedge rst) begin
    if (!rst) begin
      sck_s1 <= 1'h0;
      sck_s2 <= 1'h0;
      sck_s3 <= 1'h0;
    end else if (CE) begin
      sck_s1 <= sck_gated;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
    end
  end

  always_ff @(posedge MCLK or negedge rst) begin
    if (!rst) begin
      ws_s1 <= 1'h0;
      ws_s2 <= 1'h0;
    end else if (CE) begin
      ws_s1 <= ws_gated;
      ws_s2 <= ws_s1;
    end
  end
  // external clock shifts data on its falling edge
  wire ext_fall = sck_s3 && !sck_s2;
  wire shift_tick = MASTER ? gen_fall : ext_fall;

  // sample buffer; the ready pin must come from a flop, so the fill level
  // is mirrored here and the pin says whether the next edge may take a word
  localparam int OW = $clog2(satx_pkg::BUF_DEPTH) + 1;
  logic buf_valid, buf_take, buf_room;
  logic [DW:0] buf_data;
  logic [OW-1:0] occ;
  wire word_in = CE && WORD_VALID && WORD_READY && buf_room;
  wire word_out = CE && buf_take && buf_valid;
  wire [OW-1:0] next_occ = occ + OW'(word_in) - OW'(word_out);
  wire next_ready = (next_occ != OW'(satx_pkg::BUF_DEPTH));
  satx_buf #(.WIDTH(DW + 1), .DEPTH(satx_pkg::BUF_DEPTH)) u_buf (
    .clk(MCLK),
    .rst_n(rst),
    .ce(CE),
    .in_valid(WORD_VALID && WORD_READY),
    .in_ready(buf_room),
    .in_data({WORD_RIGHT, WORD_DATA}),
    .out_valid(buf_valid),
    .out_ready(buf_take),
    .out_data(buf_data)
  );
  always_ff @(posedge MCLK or negedge rst) begin
    if (!rst) begin
      occ <= '0;
      WORD_READY <= 1'h0;
    end else if (CE) begin
      occ <= next_occ;
      WORD_READY <= next_ready;
    end
  end

  // frame state
  typedef enum logic [1:0] {ST_IDLE, ST_LEFT, ST_RIGHT} satx_state_e;
  satx_state_e state, next_state;
  logic [CW-1:0] bitcnt, next_bitcnt;
  logic [DW-1:0] shreg, next_shreg;
  logic ws_int, next_ws_int, ws_prev;
  wire word_end = (bitcnt == CW'(WORD_BITS - 1));
  // slave: new word starts on word-select edge
  wire slave_start = !MASTER && shift_tick && (ws_s2 != ws_prev);
  wire master_start = MASTER && shift_tick && (state == ST_IDLE || word_end);
  wire load = run && (slave_start || master_start);
  assign buf_take = load;
  // underrun sends idle-high data rather than a stale word
  wire [DW-1:0] fresh = buf_valid ? buf_data[DW-1:0] : '1;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (load) next_state = ST_LEFT;
      ST_LEFT: if (load) next_state = ST_RIGHT;
      ST_RIGHT: if (load) next_state = ST_LEFT;
      default: next_state = ST_IDLE;
    endcase
    if (quiet) next_state = ST_IDLE;
  end

  // a stop or reset drops any half-sent word
  always_comb begin
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_ws_int = ws_int;
    if (quiet) begin
      next_bitcnt = '0;
      next_shreg = '1;
      next_ws_int = 1'h0;
    end else if (load) begin
      next_bitcnt = '0;
      next_shreg = fresh;
      // word select toggles with the word, on the same bit clock
      next_ws_int = MASTER ? (next_state == ST_RIGHT) : ws_s2;
    end else if (shift_tick) begin
      next_bitcnt = bitcnt + 1'h1;
      next_shreg = {shreg[DW-2:0], 1'h1};
    end
  end

  always_ff @(posedge MCLK or negedge rst) begin
    if (!rst) begin
      state <= ST_IDLE;
    end else if (CE) begin
      state <= next_state;
    end
  end

  always_ff @(posedge MCLK or negedge rst) begin
    if (!rst) begin
      bitcnt <= '0;
    end else if (CE) begin
      bitcnt <= next_bitcnt;
    end
  end

  always_ff @(posedge MCLK or negedge rst) begin
    if (!rst) begin
      shreg <= '1;
    end else if (CE) begin
      shreg <= next_shreg;
    end
  end

  always_ff @(posedge MCLK or negedge rst) begin
    if (!rst) begin
      ws_int <= 1'h0;
    end else if (CE) begin
      ws_int <= next_ws_int;
    end
  end

  always_ff @(posedge MCLK or negedge rst) begin
    if (!rst) begin
      ws_prev <= 1'h0;
    end else if (CE && shift_tick) begin
      ws_prev <= ws_s2;
    end
  end

  // msb of each transmitter's field goes out
  function automatic logic lane_bit(input logic [DW-1:0] s, input int i);
    lane_bit = s[(i + 1) * WORD_BITS - 1];
  endfunction

  // lane selection: each lane idles high unless its own transmitter runs
  wire a_on = run && TX_ENABLE[0];
  wire b_on = run && TX_ENABLE[1];
  wire c_on = run && TX_ENABLE[2];
  wire next_ser_a = a_on ? lane_bit(shreg, 0) : satx_pkg::SER_IDLE;
  wire next_ser_b = b_on ? lane_bit(shreg, 1) : satx_pkg::SER_IDLE;
  wire next_ser_c = c_on ? lane_bit(shreg, 2) : satx_pkg::SER_IDLE;

  // registered pins; enables follow the section state, never the pin
  always_ff @(posedge MCLK or negedge rst) begin
    if (!rst) begin
      TX_BIT_CLOCK_OUT <= 1'h0;
      TX_BIT_CLOCK_OE <= 1'h0;
    end else if (CE) begin
      TX_BIT_CLOCK_OUT <= gen_clk;
      TX_BIT_CLOCK_OE <= master_run;
    end
  end

  always_ff @(posedge MCLK or negedge rst) begin
    if (!rst) begin
      TX_WORD_SELECT_OUT <= 1'h0;
      TX_WORD_SELECT_OE <= 1'h0;
    end else if (CE) begin
      TX_WORD_SELECT_OUT <= ws_int;
      TX_WORD_SELECT_OE <= master_run;
    end
  end

  always_ff @(posedge MCLK or negedge rst) begin
    if (!rst) begin
      SER_OUT_A <= satx_pkg::SER_IDLE;
    end else if (CE) begin
      SER_OUT_A <= next_ser_a;
    end
  end

  always_ff @(posedge MCLK or negedge rst) begin
    if (!rst) begin
      SER_OUT_B <= satx_pkg::SER_IDLE;
    end else if (CE) begin
      SER_OUT_B <= next_ser_b;
    end
  end

  always_ff @(posedge MCLK or negedge rst) begin
    if (!rst) begin
      SER_OUT_C <= satx_pkg::SER_IDLE;
    end else if (CE) begin
      SER_OUT_C <= next_ser_c;
    end
  end
endmodule

/* File: common/satx_pkg.sv */
// shared constants for the serial audio transmit pin block
package satx_pkg;
  localparam int NUM_TX = 3;
  localparam int WORD_BITS = 24;
  localparam int MCLK_PERIOD_NS = 8;
  localparam int BCLK_PERIOD_NS = 80;
  localparam int BCLK_HALF = BCLK_PERIOD_NS / (2 * MCLK_PERIOD_NS);
  localparam logic SER_IDLE = 1'b1;
  localparam logic [WORD_BITS-1:0] WORD_RESET = 24'h000000;
  localparam int BUF_DEPTH = 2;
endpackage

/* File: verilog/satx_buf.sv */
// two-entry valid/ready buffer for sample words
module satx_buf #(
  parameter int WIDTH = 72,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [$clog2(DEPTH):0] count;
  logic [$clog2(DEPTH)-1:0] wr_ptr;
  logic [$clog2(DEPTH)-1:0] rd_ptr;
  wire do_wr = ce && in_valid && in_ready;
  wire do_rd = ce && out_valid && out_ready;
  assign in_ready = (count != DEPTH[$clog2(DEPTH):0]);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_wr) wr_ptr <= wr_ptr + 1'b1;
      if (do_rd) rd_ptr <= rd_ptr + 1'b1;
      if (do_wr && !do_rd) count <= count + 1'b1;
      else if (do_rd && !do_wr) count <= count - 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (do_wr) mem[wr_ptr] <= in_data;
  end
endmodule

/* File: tb/satx_top_props.sv */
// pin state and framing checker for satx_top
module satx_top_props #(parameter int HALF = 5) (
  // control
  input wire logic MCLK, RST_N, MASTER, SW_RESET, STOP,
  input wire logic [2:0] TX_ENABLE,
  // pins
  input wire logic TX_BIT_CLOCK_OUT, TX_BIT_CLOCK_OE,
  input wire logic TX_WORD_SELECT_OUT, TX_WORD_SELECT_OE,
  input wire logic SER_OUT_A, SER_OUT_B, SER_OUT_C
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] up;
  wire off = SW_RESET | STOP;
  wire idle = (TX_ENABLE == 3'h0) | off;
  wire act = MASTER & !idle;
  // skip the reset synchroniser latency after each release
  always_ff @(posedge MCLK or negedge RST_N)
    if (!RST_N) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  default clocking @(posedge MCLK); endclocking
  default disable iff (up != 2'h3);
  sequence held(x);
    x [*3];
  endsequence
  AST_DATA_IDLE: assert property (
    held(!TX_ENABLE[1] | off) |-> SER_OUT_B)
    else $error("lane b not high");
  AST_ALL_HIGH: assert property (
    held(off) |-> SER_OUT_A & SER_OUT_B & SER_OUT_C)
    else $error("lanes not high");
  AST_BCLK_FLOAT: assert property (held(idle) |-> !TX_BIT_CLOCK_OE)
    else $error("bit clock driven");
  AST_WS_FLOAT: assert property (held(idle) |-> !TX_WORD_SELECT_OE)
    else $error("word select driven");
  AST_SLAVE_IN: assert property (
    held(!MASTER) |-> !TX_BIT_CLOCK_OE & !TX_WORD_SELECT_OE)
    else $error("slave drives pins");
  AST_MASTER_OUT: assert property (
    held(act) |-> TX_BIT_CLOCK_OE & TX_WORD_SELECT_OE)
    else $error("master pins floating");
  AST_BCLK_HALF: assert property (
    held(act) ##0 $changed(TX_BIT_CLOCK_OUT)
    |-> ##HALF ($changed(TX_BIT_CLOCK_OUT) | !act))
    else $error("bit clock period wrong");
  AST_WS_ON_LOW: assert property (
    held(act) ##0 $changed(TX_WORD_SELECT_OUT) |-> !TX_BIT_CLOCK_OUT)
    else $error("word select moved on high clock");
  AST_DATA_ON_LOW: assert property (
    held(act & TX_ENABLE[0]) ##0 $changed(SER_OUT_A) |-> !TX_BIT_CLOCK_OUT)
    else $error("data moved on high clock");
endmodule
bind satx_top satx_top_props #(.HALF(HALF)) u_props (.MCLK, .RST_N, .MASTER,
  .SW_RESET, .STOP, .TX_ENABLE, .TX_BIT_CLOCK_OUT, .TX_BIT_CLOCK_OE,
  .TX_WORD_SELECT_OUT, .TX_WORD_SELECT_OE, .SER_OUT_A, .SER_OUT_B, .SER_OUT_C);

/* File: tb/satx_codec.sv */
// converter model: slave clocking and word capture
module satx_codec (
  input wire logic run, bclk, ws,
  input wire logic [2:0] sd,
  output logic cclk, cws, lr,
  output logic [71:0] word,
  output int cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [71:0] s;
  logic pws;
  int n;
  initial begin
    {cclk, cws, pws} = 3'h0;
    cnt = 0;
    n = 0;
    #3;
    // clock stands still outside frames
    forever #40 cclk = run & !cclk;
  end
  always @(negedge cclk) begin
    n = (n == 23) ? 0 : n + 1;
    if (n == 0) cws <= !cws;
  end
  // a word select change marks the first bit of the next word
  always @(posedge bclk) begin
    if (ws !== pws) begin
      word <= s;
      lr <= pws;
      cnt <= cnt + 1;
    end
    pws <= ws;
    s <= {s[70:48], sd[2], s[46:24], sd[1], s[22:0], sd[0]};
  end
endmodule

/* File: tb/serial_audio_transmit_pins_tb.sv */
// bench for the serial audio transmit pin block
module serial_audio_transmit_pins_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic MCLK = 1'h0, RST_N = 1'h0, MASTER = 1'h1, SW_RESET = 1'h0;
  logic STOP = 1'h0, WORD_VALID = 1'h0, WORD_RIGHT = 1'h0, run = 1'h0;
  logic [2:0] TX_ENABLE = 3'h0;
  logic [71:0] WORD_DATA = 72'h0;
  wire WORD_READY, bo, boe, wo, woe, a, b, c, cclk, cws, lr;
  wire [71:0] word;
  int cnt, miscompares = 0, n_compared = 0, cyc = 0;
  wire bclk = boe ? bo : cclk;
  wire ws = woe ? wo : cws;
  satx_top dut (.MCLK, .RST_N, .CE(1'h1), .MASTER, .TX_ENABLE, .SW_RESET,
    .STOP, .WORD_VALID, .WORD_READY, .WORD_DATA, .WORD_RIGHT,
    .TX_BIT_CLOCK_IN(bclk), .TX_BIT_CLOCK_OUT(bo), .TX_BIT_CLOCK_OE(boe),
    .TX_WORD_SELECT_IN(ws), .TX_WORD_SELECT_OUT(wo),
    .TX_WORD_SELECT_OE(woe), .SER_OUT_A(a), .SER_OUT_B(b), .SER_OUT_C(c));
  satx_codec far (.run, .bclk, .ws, .sd({c, b, a}), .cclk, .cws, .lr, .word,
    .cnt);
  initial forever #4 MCLK = !MCLK;
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 10000) begin
      miscompares++;
      finish_test;
    end
  end
  task automatic chk(string nm, logic [71:0] e, logic [71:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic push(logic [71:0] d, logic r);
    @(negedge MCLK);
    {WORD_VALID, WORD_DATA, WORD_RIGHT} = {1'h1, d, r};
    while (!WORD_READY) @(negedge MCLK);
    @(negedge MCLK);
    WORD_VALID = 1'h0;
  endtask
  task automatic nextw;
    int k;
    k = cnt;
    wait (cnt != k);
    #1;
  endtask
  // start-up alignment is open, so allow a few filler words first
  task automatic seek(string nm, logic [71:0] e);
    for (int i = 0; i < 3 && word !== e; i++) nextw;
    chk(nm, e, word);
  endtask
  task automatic t_master;
    chk("idle pins", 72'h7, {boe, woe, a, b, c});
    push(72'h123456_789ABC_A5C3F0, 1'h0);
    push(72'hFEDCBA_0F1E2D_3C4B5A, 1'h1);
    @(negedge MCLK);
    chk("ready full", 72'h0, WORD_READY);
    TX_ENABLE = 3'h7;
    seek("word 1", 72'h123456_789ABC_A5C3F0);
    chk("ws 1", 72'h0, lr);
    nextw;
    chk("word 2", 72'hFEDCBA_0F1E2D_3C4B5A, word);
    chk("ws 2", 72'h1, lr);
    chk("master oe", 72'h3, {boe, woe});
    nextw;
    chk("empty fill", {72{1'h1}}, word);
    @(negedge MCLK);
    TX_ENABLE = 3'h5;
    push(72'h111111_222222_333333, 1'h0);
    seek("lane b off", 72'h111111_FFFFFF_333333);
    $display("test master done");
  endtask
  task automatic t_off;
    for (int i = 0; i < 3; i++) begin
      @(negedge MCLK);
      {STOP, SW_RESET, TX_ENABLE} = (i == 0) ? 5'h15 : (i == 1) ? 5'h0D : 5'h0;
      repeat (4) @(negedge MCLK);
      chk("off pins", 72'h7, {boe, woe, a, b, c});
      {STOP, SW_RESET} = 2'h0;
    end
    $display("test off done");
  endtask
  task automatic t_slave;
    {MASTER, run, TX_ENABLE} = 5'h0F;
    nextw;
    push(72'h0A0B0C_0D0E0F_102030, 1'h0);
    seek("slave word", 72'h0A0B0C_0D0E0F_102030);
    chk("slave oe", 72'h0, {boe, woe});
    $display("test slave done");
  endtask
  task automatic finish_test;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge MCLK);
    RST_N = 1'h1;
    repeat (3) @(negedge MCLK);
    t_master;
    t_off;
    t_slave;
    finish_test;
  end
endmodule
